// File: src/sfrpd_pkg.sv
// Constants and helpers shared by the register space page decoder.
package sfrpd_pkg;

    // Lowest direct address that lands in register space
    localparam logic [7:0] SFRPD_REG_BASE = 8'h80;
    // Address of the page select register, decoded on every page
    localparam logic [7:0] SFRPD_PAGE_ADDR = 8'hbf;
    // Page select value after reset
    localparam logic [7:0] SFRPD_PAGE_RST = 8'h00;
    // The two implemented pages
    localparam logic [7:0] SFRPD_PAGE_LOW = 8'h00;
    localparam logic [7:0] SFRPD_PAGE_HIGH = 8'h0f;
    // Low nibbles that mark bit addressable locations
    localparam logic [3:0] SFRPD_BIT_NIB_A = 4'h0;
    localparam logic [3:0] SFRPD_BIT_NIB_B = 4'h8;
    // Position of the low nibble inside an address
    localparam int SFRPD_NIB_LSB = 0;
    // Cycles from a core strobe to the registered answer
    localparam int SFRPD_LATENCY = 1;

    // True when the location takes single-bit access
    function automatic logic sfrpd_is_bit_addr(input logic [7:0] addr);
        logic [3:0] nib;
        nib = addr[SFRPD_NIB_LSB +: 4];
        return (nib == SFRPD_BIT_NIB_A) || (nib == SFRPD_BIT_NIB_B);
    endfunction : sfrpd_is_bit_addr

    // True when the page number is one of the implemented pages
    function automatic logic sfrpd_page_ok(input logic [7:0] page);
        return (page == SFRPD_PAGE_LOW) || (page == SFRPD_PAGE_HIGH);
    endfunction : sfrpd_page_ok

endpackage : sfrpd_pkg

// File: src/sfrpd_map.sv
// Location map: which register addresses are occupied and which are paged.
`timescale 1ns/1ps
module sfrpd_map
    import sfrpd_pkg::*;
(
    input wire logic [7:0] addr_i,
    output logic occupied_o,
    output logic paged_o
);

    // Occupancy and paging of the upper address range
    always_comb begin
        occupied_o = addr_i >= SFRPD_REG_BASE;
        paged_o = 1'b0;
        if (addr_i == 8'hab || addr_i == 8'had) begin
            // Two holes in the map stay reserved
            occupied_o = 1'b0;
        end else if (addr_i inside {8'he4, 8'hc8, [8'hca:8'hcf],
                8'hc0, 8'hc1, 8'hc2, 8'hb9, [8'h91:8'h95]}) begin
            // Locations that map to a second register on the high page
            paged_o = 1'b1;
        end
    end

endmodule : sfrpd_map

// File: src/sfrpd_decoder.sv
// Register space decoder with page select for a small processor core.
`timescale 1ns/1ps
// How it works
// - Direct addresses 0x80-0xFF go to registers
// - Bit access only at nibble 0 or 8
// - Register accesses except 0xBF qualified by 8-bit page
// - Pages 0 and F only; shared identical
// - Paged addresses pick per-page registers
// - Page register at 0xBF, resets zero
// - Write sets page; read returns page
module sfrpd_decoder
    import sfrpd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] core_addr_i, // Direct address
    input wire logic core_rd_i, // Read strobe
    input wire logic core_wr_i, // Write strobe
    input wire logic core_bit_i, // Single-bit access
    input wire logic [2:0] core_bitpos_i, // Bit number for bit access
    input wire logic [7:0] core_wdata_i, // Write data
    output logic reg_stb_o, // Peripheral register strobe
    output logic reg_we_o, // Peripheral write
    output logic [7:0] reg_addr_o, // Register address
    output logic reg_alt_o, // Selects the high page register
    output logic [7:0] reg_wdata_o, // Write data passed on
    output logic reg_bit_o, // Bit access passed on
    output logic [2:0] reg_bitpos_o, // Bit number passed on
    output logic ram_stb_o, // Data RAM strobe
    output logic rvalid_o, // Page register read data valid
    output logic [7:0] rdata_o, // Page register read data
    output logic err_o, // Access refused
    output logic [7:0] page_o // Current page select
);

    // Whole state of the decoder
    typedef struct packed {
        logic [7:0] page;
        logic stb;
        logic we;
        logic [7:0] addr;
        logic alt;
        logic [7:0] wdata;
        logic bit_acc;
        logic [2:0] bitpos;
        logic ram;
        logic rvalid;
        logic [7:0] rdata;
        logic err;
    } sfrpd_state_t;

    sfrpd_state_t st_ff; // Registered state
    sfrpd_state_t nxt_st; // Next state
    logic occupied; // Location exists in the map
    logic paged; // Location has a second register
    logic acc; // Any access this cycle
    logic upper; // Address in register space
    logic hit_page; // Access to the page register
    logic bit_bad; // Bit access where not allowed

    // Location lookup, kept apart so the map can change alone
    sfrpd_map u_map (
        .addr_i(core_addr_i),
        .occupied_o(occupied),
        .paged_o(paged)
    );

    assign acc = core_rd_i | core_wr_i;
    assign upper = core_addr_i >= SFRPD_REG_BASE;
    assign hit_page = upper && (core_addr_i == SFRPD_PAGE_ADDR);
    assign bit_bad = core_bit_i && !sfrpd_is_bit_addr(core_addr_i);

    // Decode one access; all answers are registered one cycle later
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stb = 1'b0;
        nxt_st.we = 1'b0;
        nxt_st.ram = 1'b0;
        nxt_st.rvalid = 1'b0;
        nxt_st.err = 1'b0;
        if (acc) begin
            nxt_st.addr = core_addr_i;
            nxt_st.wdata = core_wdata_i;
            nxt_st.bit_acc = core_bit_i;
            nxt_st.bitpos = core_bitpos_i;
            nxt_st.we = core_wr_i;
            // Shared locations ignore the page, paged ones follow it
            nxt_st.alt = paged && (st_ff.page == SFRPD_PAGE_HIGH);
            if (!upper) begin
                // Lower half is plain data RAM
                nxt_st.ram = 1'b1;
            end else if (bit_bad) begin
                // Bit operations on byte-only locations are refused
                nxt_st.err = 1'b1;
                nxt_st.we = 1'b0;
            end else if (hit_page) begin
                // Page register answers on every page
                if (core_wr_i) begin
                    nxt_st.page = core_wdata_i;
                end else begin
                    nxt_st.rvalid = 1'b1;
                    nxt_st.rdata = st_ff.page;
                end
                nxt_st.we = 1'b0;
            end else if (!sfrpd_page_ok(st_ff.page) || !occupied) begin
                // Unimplemented page or reserved hole: no strobe at all,
                // so nothing in the peripherals is disturbed
                nxt_st.err = 1'b1;
                nxt_st.we = 1'b0;
            end else begin
                nxt_st.stb = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.page <= SFRPD_PAGE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_stb_o = st_ff.stb;
    assign reg_we_o = st_ff.we;
    assign reg_addr_o = st_ff.addr;
    assign reg_alt_o = st_ff.alt;
    assign reg_wdata_o = st_ff.wdata;
    assign reg_bit_o = st_ff.bit_acc;
    assign reg_bitpos_o = st_ff.bitpos;
    assign ram_stb_o = st_ff.ram;
    assign rvalid_o = st_ff.rvalid;
    assign rdata_o = st_ff.rdata;
    assign err_o = st_ff.err;
    assign page_o = st_ff.page;

    // Upper addresses never reach data RAM
    upper_not_ram_a: assert property (@(posedge clk_i)
        disable iff (rst_i) acc && upper |=> !ram_stb_o)
        else $error("register space access reached data RAM");

    // Lower addresses always reach data RAM
    lower_ram_a: assert property (@(posedge clk_i)
        disable iff (rst_i) acc && !upper |=> ram_stb_o && !reg_stb_o)
        else $error("low direct access missed data RAM");

    // At most one kind of answer per access, so no peripheral and the
    // RAM can both see the same cycle
    one_answer_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $onehot0({reg_stb_o, ram_stb_o, rvalid_o, err_o}))
        else $error("more than one answer in one cycle");

    // The address handed on is the one the core issued
    addr_capture_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && upper |=> reg_addr_o == $past(core_addr_i))
        else $error("register address not captured");

    // Bit strobes only at bit addressable locations
    bit_only_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        reg_stb_o && reg_bit_o |-> reg_addr_o[3:0] inside {4'h0, 4'h8})
        else $error("bit access at byte-only location");

    // Bit operations on byte-only locations are turned away
    bit_refuse_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && upper && core_bit_i && !sfrpd_is_bit_addr(core_addr_i)
        |=> err_o && !reg_stb_o)
        else $error("bit access at byte-only location not refused");

    // Bit operations at nibble 0 or 8 reach the register as bit access
    bit_pass_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && upper && core_bit_i && sfrpd_is_bit_addr(core_addr_i)
        && occupied && sfrpd_page_ok(page_o)
        |=> reg_stb_o && reg_bit_o)
        else $error("bit access at bit location not passed on");

    // No strobe on an unimplemented page
    page_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && upper && !hit_page && !sfrpd_page_ok(page_o)
        |=> !reg_stb_o && err_o)
        else $error("strobe issued on unimplemented page");

    // Byte access to a real location on a good page is strobed
    page_strobe_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && upper && !core_bit_i && !hit_page && occupied
        && sfrpd_page_ok(page_o) |=> reg_stb_o)
        else $error("valid register access not strobed");

    // Shared locations never select the high page register
    shared_same_a: assert property (@(posedge clk_i)
        disable iff (rst_i) acc && !paged |=> !reg_alt_o)
        else $error("shared location selected page copy");

    // The low page never selects a high page copy
    low_page_alt_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && page_o == SFRPD_PAGE_LOW |=> !reg_alt_o)
        else $error("low page selected high page copy");

    // Paged locations follow the high page
    paged_alt_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && paged && page_o == SFRPD_PAGE_HIGH |=> reg_alt_o)
        else $error("paged location ignored high page");

    // The page register answers whatever page is selected
    page_any_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc && hit_page && !core_bit_i |=> !err_o && !reg_stb_o)
        else $error("page select access refused");

    // Page write lands in time for the next access
    page_write_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        core_wr_i && hit_page && !bit_bad
        |=> page_o == $past(core_wdata_i))
        else $error("page select write not applied");

    // Page read returns the page then in use
    page_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        core_rd_i && !core_wr_i && hit_page && !bit_bad
        |=> rvalid_o && rdata_o == $past(page_o))
        else $error("page select read wrong");

    // Page register holds when not written
    page_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !(core_wr_i && hit_page) |=> $stable(page_o))
        else $error("page select changed without a write");

endmodule : sfrpd_decoder

// File: bench/sfrpd_core_model.sv
// Core model that issues direct-address accesses to the decoder.
`timescale 1ns/1ps
module sfrpd_core_model (
    output logic rd_o,
    output logic wr_o,
    output logic bit_o,
    output logic [2:0] pos_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // Quiet bus until the first access
    initial begin
        {rd_o, wr_o, bit_o, pos_o, addr_o, wdata_o} = '0;
    end
    // Called at a falling edge; each access lasts one cycle
    task automatic drive(input logic w, r, b, input logic [2:0] p,
                         input logic [7:0] a, d);
        rd_o = r;
        wr_o = w;
        bit_o = b;
        pos_o = p;
        // Released lines flip, so a stale value is never mistaken
        addr_o = (w | r) ? a : ~addr_o;
        wdata_o = (w | r) ? d : ~wdata_o;
    endtask : drive
endmodule : sfrpd_core_model

// File: bench/test_sfr_space_page_decoder.sv
// Self-checking bench for the register space page decoder.
`timescale 1ns/1ps
module test_sfr_space_page_decoder;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd, wr, bt, stb, we, alt, r_bit, ram, rv, err;
    logic [2:0] pos, r_pos;
    logic [7:0] addr, wdat, r_addr, r_wdat, r_rdat, page;
    logic [33:0] exp = '0; // Expected answer of the last access
    int page_m = 0; // Page the core believes is selected
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int k, a;
    int pg[4] = '{0, 15, 1, 255};
    int al[11] = '{'h93, 'he4, 'he0, 'hc9, 'he8, 'he1, 'hab, 'had, 'h80,
                   'h7f, 'hff};
    sfrpd_core_model sfrpd_core_model_i (.rd_o(rd), .wr_o(wr), .bit_o(bt),
        .pos_o(pos), .addr_o(addr), .wdata_o(wdat));
    sfrpd_decoder sfrpd_decoder_i (.clk_i(clk_i), .rst_i(rst_i),
        .core_addr_i(addr), .core_rd_i(rd), .core_wr_i(wr),
        .core_bit_i(bt), .core_bitpos_i(pos), .core_wdata_i(wdat),
        .reg_stb_o(stb), .reg_we_o(we), .reg_addr_o(r_addr),
        .reg_alt_o(alt), .reg_wdata_o(r_wdat), .reg_bit_o(r_bit),
        .reg_bitpos_o(r_pos), .ram_stb_o(ram), .rvalid_o(rv),
        .rdata_o(r_rdat), .err_o(err), .page_o(page));
    // 20 MHz clock
    initial forever #25 clk_i = ~clk_i;
    // Cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // Locations with a separate copy on the high page
    function automatic bit paged(int a);
        return a inside {'he4, ['hc0:'hc2], 'hc8, ['hca:'hcf], 'hb9,
                         ['h91:'h95]};
    endfunction : paged
    // Check the previous answer, then issue one access and model it
    task automatic op(input logic w, r, b, input int a, d, p = 5);
        logic [33:0] got;
        logic [7:0] ad, dt;
        logic s, e, m, v;
        @(negedge clk_i);
        got = {page, stb ? r_addr : 8'h00,
               rv ? r_rdat : (stb & we ? r_wdat : 8'h00), stb & r_bit,
               stb ? r_pos : 3'h0, stb, we, ram, rv, err, stb & alt};
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
        sfrpd_core_model_i.drive(w, r, b, p[2:0], a[7:0], d[7:0]);
        {ad, dt, s, e, m, v} = '0;
        if (w | r) begin
            if (a < 'h80) m = 1'b1;
            else if (a == 'hbf && !b) begin
                if (w) page_m = d & 'hff;
                else {v, dt} = {1'b1, page_m[7:0]};
            end else begin
                // Refused: bad bit nibble, hole, or unimplemented page
                e = (b && a % 8 != 0) || a == 'hab || a == 'had ||
                    !(page_m inside {0, 15});
                s = !e;
                ad = s ? a[7:0] : 8'h00;
                dt = s && w ? d[7:0] : 8'h00;
            end
        end
        exp = {page_m[7:0], ad, dt, s & b, s ? p[2:0] : 3'h0, s,
               (s | m) & w, m, v, e, s & paged(a) & (page_m == 15)};
    endtask : op
    // Reset in mid-run; the page register must fall back to zero
    task automatic do_reset();
        op(0, 0, 0, 0, 0);
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        page_m = 0;
        exp = '0;
    endtask : do_reset
    task automatic report_and_stop();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        void'($urandom(32'h1d4a3e6f));
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        op(0, 1, 0, 'hbf, 0);
        $display("test reset done");
        foreach (pg[i]) begin
            op(1, 0, 0, 'hbf, pg[i]);
            op(0, 1, 0, 'hbf, 0);
            foreach (al[j]) begin
                op(0, 1, 0, al[j], 0);
                op(1, 0, 0, al[j], i * 16 + j);
                op(1, 0, al[j] >= 'h80, al[j], 0, j);
            end
        end
        op(1, 0, 0, 'hbf, 'ha5);
        op(0, 1, 0, 'hbf, 0);
        $display("test pages done");
        repeat (400) begin
            k = $urandom;
            a = $urandom_range(255, 0);
            if (k % 8 == 0)
                op(1, 0, 0, 'hbf, k[4] ? (k[5] ? k[15:8] : 15) : 0);
            else
                op(k[0], k[1] & ~k[0], k[2] & (a >= 'h80), a, k[15:8],
                   k[18:16]);
        end
        $display("test random done");
        // Handler entry: save the page, work on page F, restore on exit
        op(1, 0, 0, 'hbf, 0);
        op(0, 1, 0, 'hbf, 0);
        a = page_m;
        op(1, 0, 0, 'hbf, 15);
        op(1, 0, 0, 'h93, 'h3c);
        op(1, 0, 0, 'hbf, a);
        op(0, 1, 0, 'h93, 0);
        $display("test handler done");
        op(1, 0, 0, 'hbf, 15);
        do_reset();
        op(0, 1, 0, 'hbf, 0);
        op(0, 0, 0, 0, 0);
        $display("test midreset done");
        report_and_stop();
    end
endmodule : test_sfr_space_page_decoder
